// >>> rtl/gpio_peripheral_pin_mux.sv
`timescale 1ns/1ps
// Function
// - Each pin offers GPIO plus up to three peripheral functions by select field.
// - Select zero means GPIO, and every field resets to zero.
// - Select values one, two, three pick peripheral selections one, two, three.
// - Pin seven's field sits at bits 15:14 of the low select register.
// - Capture one is reachable on pin five or pin twenty-four.
// - A reserved selection leaves the pin undefined; here it is released.
// - A peripheral absent on this family member makes its selection reserved.
// - Zero or several source pins give a peripheral input its default level.
// - PWM sync input and SPI enable inputs default to zero.
// - Trip, capture, quadrature, SPI data and clock, serial, CAN inputs default to one.
// - All family members share one select encoding; only reservations differ.
// - A PWM mode field adds a second stage swapping PWM A and B.
module gpio_peripheral_pin_mux
#(
  parameter logic [63:0] fn_present = 64'hffff_ffff_ffff_ffff
)
(
  // Clock, reset, enable
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Register port
  input  wire pin_mux_pkg::reg_req_t  req,
  output      logic [31:0]            rdata,
  // Device pins
  input  wire logic [31:0]            pin_in,
  output      logic [31:0]            pin_out,
  output      logic [31:0]            pin_oe,
  // GPIO function
  input  wire logic [31:0]            gpio_out,
  input  wire logic [31:0]            gpio_oe,
  output      logic [31:0]            gpio_in,
  // Peripheral side, indexed by function code
  input  wire logic [63:0]            periph_out,
  input  wire logic [63:0]            periph_oe,
  output      logic [63:0]            periph_in
);

  logic [31:0] port_a_low_pin_select;
  logic [31:0] port_a_high_pin_select;
  logic [1:0]  pwm_pin_mode_field;
  logic [31:0] pin_sync;
  logic [5:0]  code [32];
  logic [31:0] reserved;
  logic [31:0] next_pin_out;
  logic [31:0] next_pin_oe;
  logic [63:0] next_periph_in;
  logic [1:0]  hits [64];
  logic [63:0] src_level;
  logic [31:0] next_rdata;

  // Field of pin p within the two select words
  function automatic logic [1:0] sel_of(input logic [31:0] lo, input logic [31:0] hi,
                                        input int p);
    if (p < pin_mux_pkg::pins_per_reg)
      return lo[2*p +: 2];
    return hi[2*(p - pin_mux_pkg::pins_per_reg) +: 2];
  endfunction

  // Select registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      port_a_low_pin_select  <= pin_mux_pkg::sel_reset;
      port_a_high_pin_select <= pin_mux_pkg::sel_reset;
    end
    else if (ce && req.wr)
    begin
      if (req.addr == pin_mux_pkg::low_sel_addr)
        port_a_low_pin_select <= req.wdata;
      if (req.addr == pin_mux_pkg::high_sel_addr)
        port_a_high_pin_select <= req.wdata;
    end
  end

  // PWM stage mode
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pwm_pin_mode_field <= pin_mux_pkg::pwm_mode_reset;
    else if (ce && req.wr && (req.addr == pin_mux_pkg::pwm_cfg_addr))
      pwm_pin_mode_field <= req.wdata[pin_mux_pkg::pwm_mode_lsb +: pin_mux_pkg::pwm_mode_w];
  end

  // Pin synchroniser; gpio_in is the second stage
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_sync <= 32'h0000_0000;
      gpio_in  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pin_sync <= pin_in;
      gpio_in  <= pin_sync;
    end
  end

  // Read data
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (req.rd)
    begin
      unique case (req.addr)
        pin_mux_pkg::low_sel_addr:   next_rdata = port_a_low_pin_select;
        pin_mux_pkg::high_sel_addr:  next_rdata = port_a_high_pin_select;
        pin_mux_pkg::pwm_cfg_addr:   next_rdata = {30'h0000_0000, pwm_pin_mode_field};
        pin_mux_pkg::pin_level_addr: next_rdata = gpio_in;
        default:                     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= 32'h0000_0000;
    else if (ce)
      rdata <= next_rdata;
  end

  // Per-pin decode
  for (genvar p = 0; p < 32; p++)
  begin : g_pin
    pin_select_decode #(.pin(p)) u_dec
    (
      .sel      (sel_of(port_a_low_pin_select, port_a_high_pin_select, p)),
      .pwm_mode (pwm_pin_mode_field),
      .present  (fn_present),
      .code     (code[p]),
      .reserved (reserved[p])
    );
  end

  // Pin drive
  always_comb
  begin
    next_pin_out = 32'h0000_0000;
    next_pin_oe  = 32'h0000_0000;
    for (int p = 0; p < 32; p++)
    begin
      if (sel_of(port_a_low_pin_select, port_a_high_pin_select, p) == pin_mux_pkg::sel_gpio)
      begin
        next_pin_out[p] = gpio_out[p];
        next_pin_oe[p]  = gpio_oe[p];
      end
      else if (reserved[p])
      begin
        next_pin_out[p] = 1'b0;
        next_pin_oe[p]  = 1'b0;
      end
      else if (pin_mux_pkg::fn_is_out(code[p]))
      begin
        next_pin_out[p] = periph_out[code[p]];
        next_pin_oe[p]  = 1'b1;
      end
      else if (pin_mux_pkg::fn_is_bidir(code[p]))
      begin
        next_pin_out[p] = periph_out[code[p]];
        next_pin_oe[p]  = periph_oe[code[p]];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out <= 32'h0000_0000;
      pin_oe  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  // Peripheral input routing with saturating source count
  always_comb
  begin
    src_level = 64'h0000_0000_0000_0000;
    for (int f = 0; f < 64; f++)
      hits[f] = 2'h0;
    for (int p = 0; p < 32; p++)
    begin
      if (pin_mux_pkg::fn_takes_in(code[p]))
      begin
        if (hits[code[p]] != 2'h2)
          hits[code[p]] = hits[code[p]] + 2'h1;
        src_level[code[p]] = gpio_in[p];
      end
    end
    for (int f = 0; f < 64; f++)
      next_periph_in[f] = (hits[f] == 2'h1) ? src_level[f]
                                            : pin_mux_pkg::fn_in_default[f];
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      periph_in <= pin_mux_pkg::fn_in_default;
    else if (ce)
      periph_in <= next_periph_in;
  end

  // Checks
  property p_reset_gpio;
    @(posedge clock) $rose(nrst) |-> (port_a_low_pin_select == 32'h0)
                                     && (port_a_high_pin_select == 32'h0);
  endproperty
  a_reset_gpio: assert property (p_reset_gpio) else $error("select not zero after reset");

  property p_pin7_pwm;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[15:14] == 2'h1) && (pwm_pin_mode_field == 2'h0)
      && fn_present[pin_mux_pkg::fn_pwm4b]
      |=> pin_oe[7] && (pin_out[7] == $past(periph_out[pin_mux_pkg::fn_pwm4b]));
  endproperty
  a_pin7_pwm: assert property (p_pin7_pwm) else $error("pin seven not driven by pwm");

  property p_pin7_swap;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[15:14] == 2'h1) && (pwm_pin_mode_field == 2'h1)
      && fn_present[pin_mux_pkg::fn_pwm4b]
      |=> pin_out[7] == $past(periph_out[pin_mux_pkg::fn_pwm4a]);
  endproperty
  a_pin7_swap: assert property (p_pin7_swap) else $error("pwm swap stage wrong");

  property p_capture_one_function_dual;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[11:10] == 2'h3) && (port_a_high_pin_select[17:16] == 2'h1)
      && fn_present[pin_mux_pkg::fn_capture_one_function]
      |=> periph_in[pin_mux_pkg::fn_capture_one_function];
  endproperty
  a_capture_one_function_dual: assert property (p_capture_one_function_dual) else $error("doubly routed capture not high");

  property p_capture_one_function_pin24;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[11:10] != 2'h3) && (port_a_high_pin_select[17:16] == 2'h1)
      && (port_a_high_pin_select[7:6] != 2'h3) && fn_present[pin_mux_pkg::fn_capture_one_function]
      |=> periph_in[pin_mux_pkg::fn_capture_one_function] == $past(gpio_in[24]);
  endproperty
  a_capture_one_function_pin24: assert property (p_capture_one_function_pin24) else $error("capture one not from pin 24");

  property p_sync_default;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[13:12] != 2'h2) |=> !periph_in[pin_mux_pkg::fn_sync_in];
  endproperty
  a_sync_default: assert property (p_sync_default) else $error("sync input not low");

  property p_tz1_default;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[25:24] != 2'h1) |=> periph_in[pin_mux_pkg::fn_tz1];
  endproperty
  a_tz1_default: assert property (p_tz1_default) else $error("trip input not high");

  property p_gpio_pass;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_high_pin_select[31:30] == 2'h0)
      |=> (pin_oe[31] == $past(gpio_oe[31])) && (pin_out[31] == $past(gpio_out[31]));
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) else $error("gpio not passed to pin");

  property p_reserved_release;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[1:0] == 2'h2) |=> !pin_oe[0];
  endproperty
  a_reserved_release: assert property (p_reserved_release) else $error("reserved driven");

  property p_read_back;
    @(posedge clock) disable iff (!nrst)
      ce && req.rd && (req.addr == pin_mux_pkg::low_sel_addr)
      |=> rdata == $past(port_a_low_pin_select);
  endproperty
  a_read_back: assert property (p_read_back) else $error("select read back wrong");

  property p_absent_pin;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[15:14] == 2'h2) && !fn_present[pin_mux_pkg::fn_spi_ste_d]
      |=> !pin_oe[7] && !pin_out[7];
  endproperty
  a_absent_pin: assert property (p_absent_pin) else $error("absent pin driven");

  property p_input_release;
    @(posedge clock) disable iff (!nrst)
      ce && (port_a_low_pin_select[13:12] == 2'h2) |=> !pin_oe[6];
  endproperty
  a_input_release: assert property (p_input_release) else $error("input pin driven");

  c_pin7_capture: cover property (@(posedge clock) disable iff (!nrst)
    port_a_low_pin_select[15:14] == 2'h3);
  c_capture_one_function_dual: cover property (@(posedge clock) disable iff (!nrst)
    (port_a_low_pin_select[11:10] == 2'h3) && (port_a_high_pin_select[17:16] == 2'h1));
  c_pwm_swap: cover property (@(posedge clock) disable iff (!nrst)
    pwm_pin_mode_field == 2'h1);
  c_absent_sel: cover property (@(posedge clock) disable iff (!nrst)
    port_a_low_pin_select[15:14] == 2'h2);
  c_capture_one_function_pin24: cover property (@(posedge clock) disable iff (!nrst)
    (port_a_low_pin_select[11:10] != 2'h3) && (port_a_high_pin_select[17:16] == 2'h1));

endmodule

// >>> rtl/pin_mux_pkg.sv
package pin_mux_pkg;

  // Geometry
  localparam int num_pins       = 32;
  localparam int pins_per_reg   = 16;
  localparam int sel_w          = 2;
  localparam int num_fn         = 64;
  localparam int fn_w           = 6;
  localparam int addr_w         = 4;
  localparam int data_w         = 32;
  localparam int pwm_mode_lsb   = 0;
  localparam int pwm_mode_w     = 2;

  // Register word indices
  localparam logic [3:0] low_sel_addr   = 4'h0;
  localparam logic [3:0] high_sel_addr  = 4'h1;
  localparam logic [3:0] pwm_cfg_addr   = 4'h2;
  localparam logic [3:0] pin_level_addr = 4'h3;

  // Reset values
  localparam logic [31:0] sel_reset      = 32'h0000_0000;
  localparam logic [1:0]  pwm_mode_reset = 2'h0;

  // Select field codes
  localparam logic [1:0] sel_gpio = 2'h0;
  localparam logic [1:0] sel_per1 = 2'h1;
  localparam logic [1:0] sel_per2 = 2'h2;
  localparam logic [1:0] sel_per3 = 2'h3;

  // Second PWM stage modes
  localparam logic [1:0] pwm_mode_direct = 2'h0;
  localparam logic [1:0] pwm_mode_swap   = 2'h1;

  // Peripheral functions: 1..19 outputs, 20..34 inputs, 35..58 two-way
  typedef enum logic [5:0] {
    fn_none = 6'h00, fn_sync_out = 6'h01,
    fn_pwm1a = 6'h02, fn_pwm1b, fn_pwm2a, fn_pwm2b, fn_pwm3a, fn_pwm3b,
    fn_pwm4a, fn_pwm4b, fn_pwm5a, fn_pwm5b, fn_pwm6a, fn_pwm6b,
    fn_soc_a = 6'h0e, fn_soc_b, fn_can_tx_a, fn_can_tx_b, fn_sci_tx_a, fn_sci_tx_b,
    fn_sync_in = 6'h14, fn_tz1, fn_tz2, fn_tz3, fn_tz4, fn_tz5, fn_tz6,
    fn_can_rx_a, fn_can_rx_b, fn_sci_rx_a, fn_sci_rx_b, fn_qep1a, fn_qep1b,
    fn_qep2a, fn_qep2b,
    fn_capture_one_function = 6'h23, fn_cap2, fn_cap3, fn_cap4, fn_qep1s, fn_qep1i, fn_qep2s, fn_qep2i,
    fn_spi_simo_a, fn_spi_simo_b, fn_spi_simo_c, fn_spi_simo_d,
    fn_spi_somi_a, fn_spi_somi_b, fn_spi_somi_c, fn_spi_somi_d,
    fn_spi_clk_a, fn_spi_clk_b, fn_spi_clk_c, fn_spi_clk_d,
    fn_spi_ste_a, fn_spi_ste_b, fn_spi_ste_c, fn_spi_ste_d
  } fn_t;

  localparam logic [5:0] fn_first_out   = 6'h01;
  localparam logic [5:0] fn_first_in    = 6'h14;
  localparam logic [5:0] fn_first_bidir = 6'h23;
  localparam logic [5:0] fn_last        = 6'h3a;
  localparam logic [5:0] fn_last_pwm    = 6'h0d;

  // Level seen by an unrouted peripheral input: 0 for sync and SPI enables
  localparam logic [63:0] fn_in_default = 64'hf87f_ffff_ffef_ffff;

  // Per pin: peripheral selections one, two, three
  localparam fn_t fn_table [num_pins][3] = '{
    '{fn_pwm1a,      fn_none,       fn_none},
    '{fn_pwm1b,      fn_spi_simo_d, fn_none},
    '{fn_pwm2a,      fn_none,       fn_none},
    '{fn_pwm2b,      fn_spi_somi_d, fn_none},
    '{fn_pwm3a,      fn_none,       fn_none},
    '{fn_pwm3b,      fn_spi_clk_d,  fn_capture_one_function},
    '{fn_pwm4a,      fn_sync_in,    fn_sync_out},
    '{fn_pwm4b,      fn_spi_ste_d,  fn_cap2},
    '{fn_pwm5a,      fn_can_tx_b,   fn_soc_a},
    '{fn_pwm5b,      fn_sci_tx_b,   fn_cap3},
    '{fn_pwm6a,      fn_can_rx_b,   fn_soc_b},
    '{fn_pwm6b,      fn_sci_rx_b,   fn_cap4},
    '{fn_tz1,        fn_can_tx_b,   fn_spi_simo_b},
    '{fn_tz2,        fn_can_rx_b,   fn_spi_somi_b},
    '{fn_tz3,        fn_sci_tx_b,   fn_spi_clk_b},
    '{fn_tz4,        fn_sci_rx_b,   fn_spi_ste_b},
    '{fn_spi_simo_a, fn_can_tx_b,   fn_tz5},
    '{fn_spi_somi_a, fn_can_rx_b,   fn_tz6},
    '{fn_spi_clk_a,  fn_sci_tx_b,   fn_none},
    '{fn_spi_ste_a,  fn_sci_rx_b,   fn_none},
    '{fn_qep1a,      fn_spi_simo_c, fn_can_tx_b},
    '{fn_qep1b,      fn_spi_somi_c, fn_can_rx_b},
    '{fn_qep1s,      fn_spi_clk_c,  fn_sci_tx_b},
    '{fn_qep1i,      fn_spi_ste_c,  fn_sci_rx_b},
    '{fn_capture_one_function,       fn_qep2a,      fn_spi_simo_b},
    '{fn_cap2,       fn_qep2b,      fn_spi_somi_b},
    '{fn_cap3,       fn_qep2i,      fn_spi_clk_b},
    '{fn_cap4,       fn_qep2s,      fn_spi_ste_b},
    '{fn_sci_rx_a,   fn_none,       fn_tz5},
    '{fn_sci_tx_a,   fn_none,       fn_tz6},
    '{fn_can_rx_a,   fn_none,       fn_none},
    '{fn_can_tx_a,   fn_none,       fn_none}
  };

  // Register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  function automatic logic fn_is_out(input logic [5:0] c);
    return (c >= fn_first_out) && (c < fn_first_in);
  endfunction

  function automatic logic fn_takes_in(input logic [5:0] c);
    return (c >= fn_first_in) && (c <= fn_last);
  endfunction

  function automatic logic fn_is_bidir(input logic [5:0] c);
    return (c >= fn_first_bidir) && (c <= fn_last);
  endfunction

endpackage

// >>> rtl/pin_select_decode.sv
`timescale 1ns/1ps
module pin_select_decode
#(
  parameter int pin = 0
)
(
  // Pin select field and PWM stage mode
  input  wire logic [1:0]  sel,
  input  wire logic [1:0]  pwm_mode,
  // Peripherals present on this family member
  input  wire logic [63:0] present,
  // Decoded function
  output      logic [5:0]  code,
  output      logic        reserved
);

  logic [5:0] raw;

  always_comb
  begin
    raw = pin_mux_pkg::fn_none;
    if (sel != pin_mux_pkg::sel_gpio)
    begin
      raw = pin_mux_pkg::fn_table[pin][sel - 2'h1];
    end
    // Empty or absent peripheral counts as reserved
    reserved = (sel != pin_mux_pkg::sel_gpio)
               && ((raw == pin_mux_pkg::fn_none) || !present[raw]);
    code = reserved ? pin_mux_pkg::fn_none : raw;
    // Second stage swaps A and B of each PWM unit
    if ((pwm_mode == pin_mux_pkg::pwm_mode_swap) && (code >= pin_mux_pkg::fn_pwm1a)
        && (code <= pin_mux_pkg::fn_last_pwm))
    begin
      code = code ^ 6'h01;
    end
  end

endmodule

// >>> verif/periph_pin_model.sv
`timescale 1ns/1ps
module periph_pin_model
(
  // Outside pin levels and peripheral patterns from the bench
  input  wire logic [31:0] ext_level,
  input  wire logic [63:0] out_pat,
  input  wire logic [63:0] oe_pat,
  // Device pins
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  output      logic [31:0] pin_in,
  // Peripheral side
  output      logic [63:0] periph_out,
  output      logic [63:0] periph_oe
);
  // Wire level: device drive wins, else the outside level
  assign pin_in     = (pin_oe & pin_out) | (~pin_oe & ext_level);
  assign periph_out = out_pat;
  assign periph_oe  = oe_pat;
endmodule

// >>> verif/tb_gpio_peripheral_pin_mux.sv
`timescale 1ns/1ps
module tb_gpio_peripheral_pin_mux;
  logic                  clock;
  logic                  nrst;
  logic                  ce;
  pin_mux_pkg::reg_req_t req;
  logic [31:0]           rdata, pin_in, pin_out, pin_oe, gpio_out, gpio_oe, gpio_in;
  logic [31:0]           ext_level, rd_val;
  logic [63:0]           periph_out, periph_oe, periph_in, out_pat, oe_pat;
  int                    bad_count;
  int                    samples_checked;
  // One SPI function, fn_spi_ste_d, absent on this member
  localparam logic [63:0] present_cfg = ~(64'h1 << pin_mux_pkg::fn_spi_ste_d);

  gpio_peripheral_pin_mux #(.fn_present(present_cfg)) dut_u (
    .clock(clock), .nrst(nrst), .ce(ce), .req(req), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in)
  );

  periph_pin_model far_u (
    .ext_level(ext_level), .out_pat(out_pat), .oe_pat(oe_pat),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .periph_out(periph_out), .periph_oe(periph_oe)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Everything at its reset selection
  task automatic reset_state();
    for (int a = 0; a < 3; a++)
    begin
      reg_read(4'(a), rd_val);
      check(64'(rd_val), 64'h0);
    end
    check(64'(pin_oe), 64'(gpio_oe));
    check(64'(pin_out), 64'(gpio_out));
    check(64'(gpio_in), 64'((gpio_oe & gpio_out) | (~gpio_oe & ext_level)));
    check(periph_in, pin_mux_pkg::fn_in_default);
    check(64'(periph_in[pin_mux_pkg::fn_sync_in]), 64'h0);
    check(64'(periph_in[pin_mux_pkg::fn_cap2]), 64'h1);
  endtask

  // Pin seven through all three selections, two patterns
  task automatic pin_seven_select();
    logic [5:0] code;
    logic       avail;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      out_pat <= (k == 0) ? 64'hc3a5_5a3c_0ff0_a5c3 : 64'h3c5a_a5c3_f00f_5a3c;
      oe_pat  <= (k == 0) ? 64'h0f0f_f0f0_5555_aaaa : 64'hf0f0_0f0f_aaaa_5555;
      for (int s = 1; s < 4; s++)
      begin
        code = 6'(pin_mux_pkg::fn_table[7][s-1]);
        avail = present_cfg[code];
        reg_write(pin_mux_pkg::low_sel_addr, 32'(s) << 14);
        settle(2);
        check(64'(pin_out[7]), avail ? 64'(out_pat[code]) : 64'h0);
        check(64'(pin_oe[7]), !avail ? 64'h0 : (s == 1) ? 64'h1 : 64'(oe_pat[code]));
        check(64'({pin_oe[8], pin_oe[6]}), 64'({gpio_oe[8], gpio_oe[6]}));
        reg_read(pin_mux_pkg::low_sel_addr, rd_val);
        check(64'(rd_val), 64'(32'(s) << 14));
      end
    end
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0);
  endtask

  // Capture one from pin five, pin twenty-four, or both
  task automatic capture_sources();
    @(posedge clock);
    oe_pat <= 64'h0;
    ext_level[5] <= 1'b0;
    ext_level[24] <= 1'b0;
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0000_0c00);
    settle(4);
    check(64'(periph_in[pin_mux_pkg::fn_capture_one_function]), 64'h0);
    reg_write(pin_mux_pkg::high_sel_addr, 32'h0001_0000);
    settle(4);
    check(64'(periph_in[pin_mux_pkg::fn_capture_one_function]), 64'h1);
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0);
    settle(4);
    check(64'(periph_in[pin_mux_pkg::fn_capture_one_function]), 64'h0);
    reg_write(pin_mux_pkg::high_sel_addr, 32'h0);
  endtask

  // Sync input routed from pin six, then left unrouted
  task automatic sync_input();
    @(posedge clock);
    ext_level[6] <= 1'b1;
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0000_2000);
    settle(4);
    check(64'(periph_in[pin_mux_pkg::fn_sync_in]), 64'h1);
    check(64'(pin_oe[6]), 64'h0);
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0);
    settle(4);
    check(64'(periph_in[pin_mux_pkg::fn_sync_in]), 64'h0);
  endtask

  // Reserved selection on pin zero, then PWM swap stage
  task automatic reserved_and_mode();
    @(posedge clock);
    out_pat <= 64'h0000_0000_0000_0004;
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0000_0002);
    settle(2);
    check(64'({pin_oe[0], pin_out[0]}), 64'h0);
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0000_0001);
    settle(2);
    check(64'({pin_oe[0], pin_out[0]}), 64'h3);
    reg_write(pin_mux_pkg::pwm_cfg_addr, 32'(pin_mux_pkg::pwm_mode_swap));
    settle(2);
    check(64'({pin_oe[0], pin_out[0]}), 64'h2);
    reg_read(pin_mux_pkg::pwm_cfg_addr, rd_val);
    check(64'(rd_val[1:0]), 64'(pin_mux_pkg::pwm_mode_swap));
    reg_write(pin_mux_pkg::pwm_cfg_addr, 32'h0);
    reg_write(pin_mux_pkg::low_sel_addr, 32'h0);
  endtask

  // Clock enable, read-write and unmapped index
  task automatic reg_rules();
    @(posedge clock);
    ce <= 1'b0;
    reg_write(pin_mux_pkg::high_sel_addr, 32'h5555_5555);
    @(posedge clock);
    ce <= 1'b1;
    reg_read(pin_mux_pkg::high_sel_addr, rd_val);
    check(64'(rd_val), 64'h0);
    reg_write(pin_mux_pkg::high_sel_addr, 32'h5555_5555);
    reg_read(pin_mux_pkg::high_sel_addr, rd_val);
    check(64'(rd_val), 64'h5555_5555);
    reg_read(4'h5, rd_val);
    check(64'(rd_val), 64'h0);
    reg_write(pin_mux_pkg::high_sel_addr, 32'h0);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    complete_run();
  end

  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    nrst = 1'b0;
    ce = 1'b1;
    req = '0;
    gpio_out = 32'h1234_5679;
    gpio_oe = 32'h0000_ff01;
    ext_level = 32'ha5a5_0f0f;
    out_pat = 64'h0;
    oe_pat = 64'h0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    settle(4);
    reset_state();
    pin_seven_select();
    capture_sources();
    sync_input();
    reserved_and_mode();
    reg_rules();
    complete_run();
  end
endmodule
